// ### shared/pro_pkg.sv
// Purpose: constants for the reservation-out command handler
// Assumes: 32-bit classic Wishbone register map, byte addresses
// Notes:   status, sense and code values are named once here
package pro_pkg;
	// register byte offsets
	localparam logic [7:0] CDB0_OFF   = 8'h00;
	localparam logic [7:0] CDB1_OFF   = 8'h04;
	localparam logic [7:0] RKLO_OFF   = 8'h08;
	localparam logic [7:0] RKHI_OFF   = 8'h0c;
	localparam logic [7:0] SKLO_OFF   = 8'h10;
	localparam logic [7:0] SKHI_OFF   = 8'h14;
	localparam logic [7:0] PB20_OFF   = 8'h18;
	localparam logic [7:0] CTRL_OFF   = 8'h1c;
	localparam logic [7:0] STAT_OFF   = 8'h20;
	localparam logic [7:0] GEN_OFF    = 8'h24;
	localparam logic [7:0] UA_OFF     = 8'h28;
	localparam logic [7:0] SLOT_OFF   = 8'h2c;
	// control field positions
	localparam int CTRL_INIT_LSB = 0;
	localparam int CTRL_LEG_BIT  = 8;
	localparam int CTRL_ACA_BIT  = 9;
	localparam int CTRL_AOWN_LSB = 12;
	localparam int CTRL_GO_BIT   = 31;
	localparam int STAT_BUSY_BIT = 31;
	localparam int PB20_APTPL    = 0;
	// command block codes
	localparam logic [7:0] OPC_PR_OUT  = 8'h5f;
	localparam logic [15:0] PLIST_LEN  = 16'h0018;
	localparam logic [4:0] SA_REGISTER = 5'h00;
	localparam logic [4:0] SA_RESERVE  = 5'h01;
	localparam logic [4:0] SA_RELEASE  = 5'h02;
	localparam logic [4:0] SA_PREEMPT  = 5'h05;
	localparam logic [3:0] WHOLE_UNIT_SCOPE = 4'h0;
	localparam logic [3:0] TYP_WR_EX   = 4'h1;
	localparam logic [3:0] TYP_EX_AC   = 4'h3;
	localparam logic [3:0] TYP_WR_EX_RO = 4'h5;
	localparam logic [3:0] TYP_EX_AC_RO = 4'h6;
	// completion status and sense
	localparam logic [7:0] ST_GOOD     = 8'h00;
	localparam logic [7:0] ST_CHECK    = 8'h02;
	localparam logic [7:0] ST_CONFLICT = 8'h18;
	localparam logic [3:0] SK_NONE     = 4'h0;
	localparam logic [3:0] SK_ILLEGAL  = 4'h5;
	localparam logic [3:0] SK_UATTN    = 4'h6;
	localparam logic [7:0] ASC_NONE    = 8'h00;
	localparam logic [7:0] ASC_LEN_ERR = 8'h1a;
	localparam logic [7:0] ASC_BAD_FLD = 8'h24;
	localparam logic [7:0] ASC_BAD_REL = 8'h26;
	localparam logic [7:0] ASC_PREEMPT = 8'h2a;
	// reset values
	localparam logic [31:0] GEN_RST    = 32'h0000_0000;
	localparam logic [31:0] WORD_RST   = 32'h0000_0000;
endpackage

// ### design/pro_handler.sv
// Purpose: reservation-out command interpreter with key table
// Assumes: software loads command block and parameters, then sets go
// Notes:   one command runs per go; result appears two edges later
//
// Decided for this implementation: the address map and the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - opcode 5Fh, action byte1, scope/type byte2
// - active legacy unit reservation gives conflict
// - parameter length not 18h gives length error
// - only actions 0,1,2,5; others invalid field
// - register unknown key adds new registration
// - register key owned elsewhere gives conflict
// - register own key replaces it
// - at most four keys; fifth gives conflict
// - generation bumps on good register or preempt
// - any key registered blocks legacy reserve/release
// - unregistered requester gets conflict except register
// - key owned by other initiator gives conflict
// - conflicting new reservation gives conflict
// - reservation applies only to later commands
// - release of unreserved key is good, no change
// - release scope/type mismatch gives invalid release
// - preempt unknown key reserves without preempting
// - preempt known key reserves, clears key, flushes
// - cleared key's owner gets preempted attention
// - aca survives preempt; others held meanwhile
// - only whole unit scope; ignored for register
// - only types 1,3,5,6; ignored for register
// - keys at bytes 0-15, flag byte20 bit0
// - generation cleared to zero by reset
module pro_handler #(
	parameter int NSLOT = 4,
	parameter int IW    = 3
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             legacy_block_o,
	output logic             reconnect_hold_o,
	output logic             flush_o,
	output logic [IW-1:0]    flush_init_o
);
	localparam int NI = 1 << IW;

	typedef struct packed {
		logic [NSLOT-1:0]            vld;
		logic [NSLOT-1:0][63:0]      key;
		logic [NSLOT-1:0][IW-1:0]    own;
		logic [NSLOT-1:0]            rsv;
		logic [NSLOT-1:0][3:0]       scp;
		logic [NSLOT-1:0][3:0]       typ;
		logic [31:0]                 cdb0;
		logic [15:0]                 plen;
		logic [63:0]                 rkey;
		logic [63:0]                 skey;
		logic                        aptpl_in;
		logic                        aptpl;
		logic [IW-1:0]               init;
		logic                        leg;
		logic                        aca;
		logic [IW-1:0]               aca_own;
		logic                        exec;
		logic [7:0]                  st;
		logic [3:0]                  sk;
		logic [7:0]                  asc;
		logic [31:0]                 gen;
		logic [NI-1:0]               ua;
		logic                        ack;
		logic [31:0]                 dat;
		logic                        lblk;
		logic                        hold;
		logic                        flush;
		logic [IW-1:0]               finit;
	} pro_state_t;

	pro_state_t r_reg;
	pro_state_t r_next;

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] m;
		m = o;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				m[b*8 +: 8] = d[b*8 +: 8];
			end
		end
		return m;
	endfunction

	// an existing write-exclusive or exclusive-access hold blocks everything;
	// registrants-only holds block only the two exclusive kinds
	function automatic logic clash(input logic [3:0] old_t, input logic [3:0] new_t);
		return (old_t == pro_pkg::TYP_WR_EX) || (old_t == pro_pkg::TYP_EX_AC) ||
			(new_t == pro_pkg::TYP_WR_EX) || (new_t == pro_pkg::TYP_EX_AC);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic [31:0]       w;
		logic [NI-1:0]     ua_clr;
		logic [NI-1:0]     ua_set;
		logic [7:0]        opc;
		logic [4:0]        sa;
		logic [3:0]        scope;
		logic [3:0]        ntyp;
		logic              rk_hit;
		logic              sk_hit;
		logic              req_reg;
		logic              free;
		logic              cfl;
		logic              cfl_ex;
		logic [$clog2(NSLOT)-1:0] rk_s;
		logic [$clog2(NSLOT)-1:0] sk_s;
		logic [$clog2(NSLOT)-1:0] fr_s;
		w = 32'h0;
		ua_clr = '0;
		ua_set = '0;
		opc = r_reg.cdb0[7:0];
		sa = r_reg.cdb0[12:8];
		scope = r_reg.cdb0[23:20];
		ntyp = r_reg.cdb0[19:16];
		rk_hit = 1'b0;
		sk_hit = 1'b0;
		req_reg = 1'b0;
		free = 1'b0;
		cfl = 1'b0;
		cfl_ex = 1'b0;
		rk_s = '0;
		sk_s = '0;
		fr_s = '0;
		r_next = r_reg;
		r_next.ack = 1'b0;
		r_next.exec = 1'b0;
		r_next.flush = 1'b0;

		////////////////////////////////////////////////////////////////////////
		// register bus slave: one wait state, unmapped reads zero
		if (wb_cyc_i && wb_stb_i && !r_reg.ack) begin
			r_next.ack = 1'b1;
			if (wb_adr_i == pro_pkg::CDB0_OFF) begin
				w = r_reg.cdb0;
			end else if (wb_adr_i == pro_pkg::CDB1_OFF) begin
				w = {16'h0, r_reg.plen};
			end else if (wb_adr_i == pro_pkg::RKLO_OFF) begin
				w = r_reg.rkey[31:0];
			end else if (wb_adr_i == pro_pkg::RKHI_OFF) begin
				w = r_reg.rkey[63:32];
			end else if (wb_adr_i == pro_pkg::SKLO_OFF) begin
				w = r_reg.skey[31:0];
			end else if (wb_adr_i == pro_pkg::SKHI_OFF) begin
				w = r_reg.skey[63:32];
			end else if (wb_adr_i == pro_pkg::PB20_OFF) begin
				w = {30'h0, r_reg.aptpl, r_reg.aptpl_in};
			end else if (wb_adr_i == pro_pkg::CTRL_OFF) begin
				w[pro_pkg::CTRL_INIT_LSB +: IW] = r_reg.init;
				w[pro_pkg::CTRL_LEG_BIT] = r_reg.leg;
				w[pro_pkg::CTRL_ACA_BIT] = r_reg.aca;
				w[pro_pkg::CTRL_AOWN_LSB +: IW] = r_reg.aca_own;
			end else if (wb_adr_i == pro_pkg::STAT_OFF) begin
				w = {r_reg.exec, 7'h0, r_reg.asc, 4'h0, r_reg.sk, r_reg.st};
			end else if (wb_adr_i == pro_pkg::GEN_OFF) begin
				w = r_reg.gen;
			end else if (wb_adr_i == pro_pkg::UA_OFF) begin
				w[NI-1:0] = r_reg.ua;
			end else if (wb_adr_i == pro_pkg::SLOT_OFF) begin
				w[NSLOT-1:0] = r_reg.vld;
				w[8 +: NSLOT] = r_reg.rsv;
			end
			r_next.dat = wb_we_i ? 32'h0 : w;
			if (wb_we_i) begin
				w = merge(w, wb_dat_i, wb_sel_i);
				if (wb_adr_i == pro_pkg::CDB0_OFF) begin
					r_next.cdb0 = w;
				end else if (wb_adr_i == pro_pkg::CDB1_OFF) begin
					r_next.plen = w[15:0];
				end else if (wb_adr_i == pro_pkg::RKLO_OFF) begin
					r_next.rkey[31:0] = w;
				end else if (wb_adr_i == pro_pkg::RKHI_OFF) begin
					r_next.rkey[63:32] = w;
				end else if (wb_adr_i == pro_pkg::SKLO_OFF) begin
					r_next.skey[31:0] = w;
				end else if (wb_adr_i == pro_pkg::SKHI_OFF) begin
					r_next.skey[63:32] = w;
				end else if (wb_adr_i == pro_pkg::PB20_OFF) begin
					r_next.aptpl_in = w[pro_pkg::PB20_APTPL];
				end else if (wb_adr_i == pro_pkg::CTRL_OFF) begin
					r_next.init = w[pro_pkg::CTRL_INIT_LSB +: IW];
					r_next.leg = w[pro_pkg::CTRL_LEG_BIT];
					r_next.aca = w[pro_pkg::CTRL_ACA_BIT];
					r_next.aca_own = w[pro_pkg::CTRL_AOWN_LSB +: IW];
					r_next.exec = w[pro_pkg::CTRL_GO_BIT];
				end else if (wb_adr_i == pro_pkg::UA_OFF) begin
					ua_clr = w[NI-1:0];
				end
			end
		end

		////////////////////////////////////////////////////////////////////////
		// key table lookup
		for (int i = 0; i < NSLOT; i++) begin
			if (r_reg.vld[i] && r_reg.key[i] == r_reg.rkey) begin
				rk_hit = 1'b1;
				rk_s = i[$clog2(NSLOT)-1:0];
			end
			if (r_reg.vld[i] && r_reg.key[i] == r_reg.skey) begin
				sk_hit = 1'b1;
				sk_s = i[$clog2(NSLOT)-1:0];
			end
			if (r_reg.vld[i] && r_reg.own[i] == r_reg.init) begin
				req_reg = 1'b1;
			end
			if (!r_reg.vld[i] && !free) begin
				free = 1'b1;
				fr_s = i[$clog2(NSLOT)-1:0];
			end
		end
		for (int i = 0; i < NSLOT; i++) begin
			if (r_reg.vld[i] && r_reg.rsv[i] && clash(r_reg.typ[i], ntyp)) begin
				cfl = 1'b1;
				if (!(sk_hit && i == int'(sk_s))) begin
					cfl_ex = 1'b1;
				end
			end
		end

		////////////////////////////////////////////////////////////////////////
		// command execution, one cycle after go
		if (r_reg.exec) begin
			r_next.st = pro_pkg::ST_GOOD;
			r_next.sk = pro_pkg::SK_NONE;
			r_next.asc = pro_pkg::ASC_NONE;
			if (r_reg.leg) begin
				r_next.st = pro_pkg::ST_CONFLICT;
			end else if (opc != pro_pkg::OPC_PR_OUT) begin
				r_next.st = pro_pkg::ST_CHECK;
				r_next.sk = pro_pkg::SK_ILLEGAL;
				r_next.asc = pro_pkg::ASC_BAD_FLD;
			end else if (r_reg.plen != pro_pkg::PLIST_LEN) begin
				r_next.st = pro_pkg::ST_CHECK;
				r_next.sk = pro_pkg::SK_ILLEGAL;
				r_next.asc = pro_pkg::ASC_LEN_ERR;
			end else if (sa != pro_pkg::SA_REGISTER && sa != pro_pkg::SA_RESERVE &&
				sa != pro_pkg::SA_RELEASE && sa != pro_pkg::SA_PREEMPT) begin
				r_next.st = pro_pkg::ST_CHECK;
				r_next.sk = pro_pkg::SK_ILLEGAL;
				r_next.asc = pro_pkg::ASC_BAD_FLD;
			end else if (sa == pro_pkg::SA_REGISTER) begin
				// scope and type not examined here
				if (rk_hit && r_reg.own[rk_s] != r_reg.init) begin
					r_next.st = pro_pkg::ST_CONFLICT;
				end else if (rk_hit) begin
					r_next.key[rk_s] = r_reg.skey;
					r_next.aptpl = r_reg.aptpl_in;
					r_next.gen = r_reg.gen + 32'h1;
				end else if (!free) begin
					r_next.st = pro_pkg::ST_CONFLICT;
				end else begin
					r_next.vld[fr_s] = 1'b1;
					r_next.key[fr_s] = r_reg.skey;
					r_next.own[fr_s] = r_reg.init;
					r_next.rsv[fr_s] = 1'b0;
					r_next.aptpl = r_reg.aptpl_in;
					r_next.gen = r_reg.gen + 32'h1;
				end
			end else if (scope != pro_pkg::WHOLE_UNIT_SCOPE) begin
				r_next.st = pro_pkg::ST_CHECK;
				r_next.sk = pro_pkg::SK_ILLEGAL;
				r_next.asc = pro_pkg::ASC_BAD_FLD;
			end else if (ntyp != pro_pkg::TYP_WR_EX && ntyp != pro_pkg::TYP_EX_AC &&
				ntyp != pro_pkg::TYP_WR_EX_RO && ntyp != pro_pkg::TYP_EX_AC_RO) begin
				r_next.st = pro_pkg::ST_CHECK;
				r_next.sk = pro_pkg::SK_ILLEGAL;
				r_next.asc = pro_pkg::ASC_BAD_FLD;
			end else if (!req_reg) begin
				r_next.st = pro_pkg::ST_CONFLICT;
			end else if (rk_hit && r_reg.own[rk_s] != r_reg.init) begin
				r_next.st = pro_pkg::ST_CONFLICT;
			end else if (sa == pro_pkg::SA_RELEASE) begin
				if (!rk_hit || !r_reg.rsv[rk_s]) begin
					r_next.st = pro_pkg::ST_GOOD;
				end else if (r_reg.scp[rk_s] != scope || r_reg.typ[rk_s] != ntyp) begin
					r_next.st = pro_pkg::ST_CHECK;
					r_next.sk = pro_pkg::SK_ILLEGAL;
					r_next.asc = pro_pkg::ASC_BAD_REL;
				end else begin
					r_next.rsv[rk_s] = 1'b0;
				end
			end else if (!rk_hit) begin
				// holding a reservation needs the requester's own key
				r_next.st = pro_pkg::ST_CONFLICT;
			end else if (sa == pro_pkg::SA_RESERVE) begin
				if (cfl) begin
					r_next.st = pro_pkg::ST_CONFLICT;
				end else begin
					r_next.rsv[rk_s] = 1'b1;
					r_next.scp[rk_s] = scope;
					r_next.typ[rk_s] = ntyp;
				end
			end else if (cfl_ex) begin
				r_next.st = pro_pkg::ST_CONFLICT;
			end else begin
				// preempt and clear; aca state left untouched
				if (sk_hit && sk_s != rk_s) begin
					r_next.vld[sk_s] = 1'b0;
					r_next.rsv[sk_s] = 1'b0;
					r_next.flush = 1'b1;
					r_next.finit = r_reg.own[sk_s];
					ua_set[r_reg.own[sk_s]] = 1'b1;
				end
				r_next.rsv[rk_s] = 1'b1;
				r_next.scp[rk_s] = scope;
				r_next.typ[rk_s] = ntyp;
				r_next.gen = r_reg.gen + 32'h1;
			end
		end

		// a new preempted attention beats a clear in the same cycle
		r_next.ua = (r_reg.ua & ~ua_clr) | ua_set;
		r_next.lblk = |r_reg.vld;
		r_next.hold = r_reg.aca && (r_reg.init != r_reg.aca_own);
	end

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r_reg      <= '0;
			r_reg.gen  <= pro_pkg::GEN_RST;
			r_reg.plen <= pro_pkg::WORD_RST[15:0];
		end else begin
			r_reg <= r_next;
		end
	end

	assign wb_dat_o = r_reg.dat;
	assign wb_ack_o = r_reg.ack;
	assign legacy_block_o = r_reg.lblk;
	assign reconnect_hold_o = r_reg.hold;
	assign flush_o = r_reg.flush;
	assign flush_init_o = r_reg.finit;
endmodule

`default_nettype wire

// ### bench/pro_handler_sva.sv
// Purpose: port-level checks for the reservation-out handler
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to every pro_handler instance
`timescale 1ns/100ps
`default_nettype none
module pro_handler_sva #(
	parameter int IW = 3
) (
	input wire logic          clk_i,
	input wire logic          rst_i,
	input wire logic          wb_cyc_i,
	input wire logic          wb_stb_i,
	input wire logic          wb_we_i,
	input wire logic [7:0]    wb_adr_i,
	input wire logic [3:0]    wb_sel_i,
	input wire logic [31:0]   wb_dat_i,
	input wire logic [31:0]   wb_dat_o,
	input wire logic          wb_ack_o,
	input wire logic          legacy_block_o,
	input wire logic          reconnect_hold_o,
	input wire logic          flush_o,
	input wire logic [IW-1:0] flush_init_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic ctl_wr;
	logic go;
	assign ctl_wr = wb_ack_o && wb_we_i && wb_adr_i == pro_pkg::CTRL_OFF;
	assign go = ctl_wr && wb_dat_i[pro_pkg::CTRL_GO_BIT];
	////////////////////////////////////////////////////////////////////////
	ack_wait_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack not one cycle after request");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held two cycles");
	ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	zero_data_a: assert property (wb_ack_o && (wb_we_i || wb_adr_i > pro_pkg::SLOT_OFF)
		|-> wb_dat_o == 32'h0000_0000) else $error("write or unmapped data not zero");
	busy_short_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == pro_pkg::STAT_OFF
		|-> !wb_dat_o[pro_pkg::STAT_BUSY_BIT]) else $error("status still busy");
	flush_one_a: assert property (flush_o |=> !flush_o)
		else $error("flush longer than one cycle");
	flush_go_a: assert property (flush_o |-> $past(go))
		else $error("flush without command");
	flush_id_a: assert property ($changed(flush_init_o) && !$past(rst_i) |-> flush_o)
		else $error("flush id moved without flush");
	legacy_keep_a: assert property (legacy_block_o |=> legacy_block_o)
		else $error("legacy block dropped");
	legacy_rise_a: assert property ($rose(legacy_block_o) |-> $past(go) || $past(go, 2))
		else $error("legacy block without command");
	hold_src_a: assert property ($changed(reconnect_hold_o) && !$past(rst_i)
		|-> ctl_wr || $past(ctl_wr)) else $error("hold moved without control write");
endmodule

bind pro_handler pro_handler_sva #(.IW(IW)) u_sva (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .legacy_block_o(legacy_block_o),
	.reconnect_hold_o(reconnect_hold_o), .flush_o(flush_o), .flush_init_o(flush_init_o)
);
`default_nettype wire

// ### bench/pro_initiators.sv
// Purpose: initiator-side model receiving command-queue flushes
// Assumes: one flush pulse clears one initiator's queue
// Notes:   only counts flushes and keeps the last victim
`timescale 1ns/100ps
`default_nettype none
module pro_initiators (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       flush_i,
	input  wire logic [2:0] flush_init_i,
	output logic      [7:0] flushes_o,
	output logic      [2:0] last_o
);
	always @(posedge clk_i) begin
		if (rst_i) begin
			flushes_o <= 8'h00;
			last_o    <= 3'h0;
		end else if (flush_i) begin
			flushes_o <= flushes_o + 8'h01;
			last_o    <= flush_init_i;
		end
	end
endmodule
`default_nettype wire

// ### bench/persistent_reservation_out_handler_tb.sv
// Purpose: self-checking bench for the reservation-out handler
// Assumes: one wait state on every bus access
// Notes:   model keeps the key table, generation and attention bits
`timescale 1ns/100ps
`default_nettype none
module persistent_reservation_out_handler_tb;
	localparam logic [31:0] GOOD = {24'h0, pro_pkg::ST_GOOD};
	localparam logic [31:0] CF = {24'h0, pro_pkg::ST_CONFLICT};
	localparam logic [31:0] LE = {8'h0, pro_pkg::ASC_LEN_ERR, 4'h0, pro_pkg::SK_ILLEGAL, 8'h02};
	localparam logic [31:0] BF = {8'h0, pro_pkg::ASC_BAD_FLD, 4'h0, pro_pkg::SK_ILLEGAL, 8'h02};
	localparam logic [31:0] BR = {8'h0, pro_pkg::ASC_BAD_REL, 4'h0, pro_pkg::SK_ILLEGAL, 8'h02};
	logic        clk_i, rst_i, cyc, stb, we, ack, leg_o, hold_o, fl_o;
	logic [7:0]  adr, p_cnt;
	logic [3:0]  sel;
	logic [31:0] wdat, rdat, q;
	logic [2:0]  fl_id, p_last;
	logic [63:0] kk[8], mk[4];
	int          err_count, checks, gen, ua, nfl, lfl, aown, mo[4], mt[4];
	bit          leg, aca, mv[4], mr[4];
	pro_handler #(.NSLOT(4), .IW(3)) dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.legacy_block_o(leg_o), .reconnect_hold_o(hold_o), .flush_o(fl_o), .flush_init_o(fl_id));
	pro_initiators u_init (.clk_i(clk_i), .rst_i(rst_i), .flush_i(fl_o),
		.flush_init_i(fl_id), .flushes_o(p_cnt), .last_o(p_last));
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic cmp(string n, logic [31:0] e, logic [31:0] s);
		checks++;
		if (s !== e) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	// request held until ack is sampled; ack read before this edge lands
	task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hf;
		// no wait limit here: only the watchdog ends a hung access
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
		cmp("ack drop", 32'h0, {31'h0, ack});
	endtask
	function automatic bit clash(int ty, int skip);
		bit c;
		c = 0;
		for (int p = 0; p < 4; p++)
			if (mr[p] && p != skip && (mt[p] inside {1, 3} || ty inside {1, 3})) c = 1;
		return c;
	endfunction
	function automatic logic [31:0] mdl(int i, int a, int sc, int ty, int len,
			logic [63:0] rk, logic [63:0] sk);
		int r, k, s;
		r = -1;
		k = -1;
		s = -1;
		if (leg) return CF;
		if (len != 24) return LE;
		if (!(a inside {0, 1, 2, 5})) return BF;
		for (int p = 3; p >= 0; p--) begin
			if (mv[p] && mo[p] == i) r = p;
			if (mv[p] && mk[p] == rk) k = p;
			if (mv[p] && mk[p] == sk) s = p;
		end
		if (a == 0) begin
			if (k >= 0 && mo[k] != i) return CF;
			if (k < 0) begin
				for (int p = 3; p >= 0; p--) if (!mv[p]) k = p;
				if (k < 0) return CF;
				mv[k] = 1;
				mo[k] = i;
			end
			mk[k] = sk;
			gen++;
			return GOOD;
		end
		if (sc != 0 || !(ty inside {1, 3, 5, 6})) return BF;
		if (r < 0) return CF;
		if (k >= 0 && mo[k] != i) return CF;
		if (a == 2) begin
			if (k < 0 || !mr[k]) return GOOD;
			if (mt[k] != ty) return BR;
			mr[k] = 0;
			return GOOD;
		end
		if (k < 0 || clash(ty, a == 5 ? s : -1)) return CF;
		mr[k] = 1;
		mt[k] = ty;
		if (a == 5) gen++;
		if (a == 5 && s >= 0 && s != k) begin
			mv[s] = 0;
			mr[s] = 0;
			ua |= 1 << mo[s];
			nfl++;
			lfl = mo[s];
		end
		return GOOD;
	endfunction
	task automatic cmd(int i, int a, int sc, int ty, int len, logic [63:0] rk, logic [63:0] sk);
		logic [31:0] e;
		e = mdl(i, a, sc, ty, len, rk, sk);
		bus(1, pro_pkg::CDB0_OFF, {8'h00, sc[3:0], ty[3:0], 3'h0, a[4:0], 8'h5f});
		bus(1, pro_pkg::CDB1_OFF, {16'h0000, len[15:0]});
		bus(1, pro_pkg::RKLO_OFF, rk[31:0]);
		bus(1, pro_pkg::RKHI_OFF, rk[63:32]);
		bus(1, pro_pkg::SKLO_OFF, sk[31:0]);
		bus(1, pro_pkg::SKHI_OFF, sk[63:32]);
		bus(1, pro_pkg::PB20_OFF, {31'h0, 1'($urandom)});
		bus(1, pro_pkg::CTRL_OFF, {1'b1, 16'h0, 3'(aown), 2'h0, aca, leg, 5'h0, 3'(i)});
		bus(0, pro_pkg::STAT_OFF, 32'h0);
		cmp("status", e, q);
		bus(0, pro_pkg::GEN_OFF, 32'h0);
		cmp("generation", gen, q);
		bus(0, pro_pkg::UA_OFF, 32'h0);
		cmp("attention", ua, q);
		cmp("flushes", nfl, {24'h0, p_cnt});
		cmp("flushed id", lfl, {29'h0, p_last});
		cmp("legacy block", mv.or(), {31'h0, leg_o});
		cmp("hold", aca && i != aown, {31'h0, hold_o});
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10000) @(posedge clk_i);
		err_count++;
		give_verdict();
	end
	initial begin
		rst_i = 1'b1;
		{cyc, stb, we, adr, sel, wdat} = '0;
		void'($urandom(32'h16a738b2));
		for (int j = 0; j < 8; j++) kk[j] = {$urandom, $urandom};
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		bus(0, pro_pkg::GEN_OFF, 32'h0);
		cmp("generation", 32'h0, q);
		cmd(0, 1, 0, 1, 24, kk[0], 0);
		cmd(0, 0, 0, 0, 23, 0, kk[0]);
		for (int a = 0; a < 32; a++) if (!(a inside {0, 1, 2, 5})) cmd(0, a, 0, 1, 24, 0, 0);
		for (int j = 0; j < 4; j++) cmd(j, 0, j + 4, j, 24, 0, kk[j]);
		cmd(4, 0, 0, 0, 24, 0, kk[4]);
		cmd(1, 0, 0, 0, 24, kk[0], kk[5]);
		cmd(0, 0, 0, 0, 24, kk[0], kk[4]);
		kk[0] = kk[4];
		for (int s = 1; s < 16; s++) cmd(0, 1, s, 5, 24, kk[0], 0);
		for (int t = 0; t < 16; t++) if (!(t inside {1, 3, 5, 6})) cmd(0, 1, 0, t, 24, kk[0], 0);
		cmd(1, 1, 0, 5, 24, kk[0], 0);
		cmd(0, 1, 0, 5, 24, kk[0], 0);
		cmd(1, 1, 0, 6, 24, kk[1], 0);
		cmd(2, 1, 0, 1, 24, kk[2], 0);
		cmd(1, 2, 0, 5, 24, kk[1], 0);
		cmd(2, 2, 0, 1, 24, kk[2], 0);
		cmd(1, 2, 0, 6, 24, kk[1], 0);
		aca = 1;
		aown = 3;
		cmd(2, 5, 0, 5, 24, kk[2], kk[3]);
		cmd(3, 1, 0, 5, 24, kk[3], 0);
		aca = 0;
		cmd(1, 5, 0, 6, 24, kk[1], kk[6]);
		leg = 1;
		cmd(0, 1, 0, 5, 24, kk[0], 0);
		leg = 0;
		bus(1, pro_pkg::GEN_OFF, $urandom);
		bus(0, pro_pkg::GEN_OFF, 32'h0);
		cmp("generation", gen, q);
		bus(0, 8'h40, 32'h0);
		cmp("unmapped", 32'h0, q);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		bus(0, pro_pkg::GEN_OFF, 32'h0);
		cmp("generation", 32'h0, q);
		give_verdict();
	end
endmodule
`default_nettype wire
